// ==== rtl/cacm_sync.sv ====
// Two-stage synchroniser for a level from outside the system clock domain.
// Assumes only the second stage is read by downstream logic.
`timescale 1ns/1ps
module cacm_sync (
  input  wire logic sys_clk_i,
  input  wire logic reset_n_i,
  input  wire logic async_i,
  output logic      sync_o
);

  logic stage1_reg;
  logic stage2_reg;

  // Two flops in series, first stage read only by the second
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
    end else begin
      stage1_reg <= async_i;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_o = stage2_reg;

endmodule // cacm_sync

// ==== rtl/cacm_tick.sv ====
// Counter clock selector: one-cycle advance pulses from the chosen source.
// Assumes the external count input is already synchronised.
`timescale 1ns/1ps
module cacm_tick
  import cacm_pkg::*;
(
  input  wire logic                  sys_clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic                  run_i,
  input  wire logic [CACM_SRC_W-1:0] src_i,
  input  wire logic                  ext_sync_i,
  output logic                       tick_o
);

  logic [CACM_PRE_W-1:0] pre_reg;
  logic [CACM_PRE_W-1:0] pre_next;
  logic                  ext_prev_reg;
  logic                  ext_prev_next;
  logic [CACM_PRE_W-1:0] limit;

  // Prescaler and external edge detect
  always_comb begin
    limit         = (src_i == CACM_SRC_DIV4) ? CACM_PRE_W'(CACM_DIV4 - 1)
                                             : CACM_PRE_W'(CACM_DIV12 - 1);
    ext_prev_next = ext_sync_i;
    pre_next      = pre_reg;
    tick_o        = 1'b0;
    if (run_i) begin
      case (src_i)
        CACM_SRC_SYS: tick_o = 1'b1;
        CACM_SRC_EXT: tick_o = ext_sync_i & ~ext_prev_reg;
        default: begin
          if (pre_reg >= limit) begin
            pre_next = '0;
            tick_o   = 1'b1;
          end else begin
            pre_next = pre_reg + 1'b1;
          end
        end
      endcase
    end else begin
      pre_next = '0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pre_reg      <= '0;
      ext_prev_reg <= 1'b0;
    end else begin
      pre_reg      <= pre_next;
      ext_prev_reg <= ext_prev_next;
    end
  end

endmodule // cacm_tick

// ==== rtl/cacm_top.sv ====
// Counter array compare module: shared 16-bit counter, one compare channel
// with software timer, frequency output and 16-bit PWM modes, APB registers.
// Assumes an APB master on sys_clk_i and external logic on the module pin.
//
// Contract
// - Timer mode sets flag on counter equality
// - Flag requests interrupt, software clears it
// - Comparator plus flag enable select timer
// - Low write clears enable, high sets
// - Frequency mode toggles pin, advances low byte
// - High byte zero means 256 clocks
// - Comparator, toggle, PWM bits select frequency
// - Frequency mode flag on full equality
// - Wide PWM: high on match, low on overflow
// - Comparator, PWM, wide bits select PWM16
// - Wide PWM flag marks rising edge
// - Software updates compare on match interrupts
// - Duty equals 65536 minus compare over 65536
// - Cleared comparator in PWM drives zero
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
module cacm_top
  import cacm_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        ext_count_i,
  input  wire logic        module_io_pin_i,
  output logic             module_io_pin_o,
  output logic             module_io_pin_oe_o,
  output logic             irq_o
);

  logic                  run_reg;
  logic                  run_next;
  logic [CACM_SRC_W-1:0] clock_source_select_reg;
  logic [CACM_SRC_W-1:0] clock_source_select_next;
  logic [CACM_MODE_W-1:0] module_mode_reg;
  logic [CACM_MODE_W-1:0] module_mode_next;
  logic [7:0]            compare_low_byte_reg;
  logic [7:0]            compare_low_byte_next;
  logic [7:0]            compare_high_byte_reg;
  logic [7:0]            compare_high_byte_next;
  logic [CACM_CNT_W-1:0] count_reg;
  logic [CACM_CNT_W-1:0] count_next;
  logic                  fresh_reg;
  logic                  fresh_next;
  logic                  wrap_reg;
  logic                  wrap_next;
  logic [CACM_ST_W-1:0]  status_reg;
  logic [CACM_ST_W-1:0]  status_next;
  logic [CACM_ST_W-1:0]  mask_reg;
  logic [CACM_ST_W-1:0]  mask_next;
  logic                  pin_reg;
  logic                  pin_next;
  logic [31:0]           prdata_reg;
  logic [31:0]           prdata_next;

  logic                  tick;
  logic                  ext_sync;
  logic                  pin_sync;
  logic                  wr_en;
  logic                  setup;
  logic                  addr_ok;
  logic [CACM_ST_W-1:0]  events;
  logic                  overflow;
  logic                  full_match;
  logic                  low_match;
  logic                  comparator_enable;
  logic                  match_flag_enable;
  logic                  toggle_enable;
  logic                  pwm_enable;
  logic                  wide_pwm_select;
  logic [CACM_CNT_W-1:0] compare_value;
  cacm_mode_type         mode;

  // External count input enters through two flops
  cacm_sync u_ext_sync (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .async_i   (ext_count_i),
    .sync_o    (ext_sync)
  );

  cacm_sync u_pin_sync (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .async_i   (module_io_pin_i),
    .sync_o    (pin_sync)
  );

  // Counter advance pulses from the selected clock
  cacm_tick u_tick (
    .sys_clk_i  (sys_clk_i),
    .reset_n_i  (reset_n_i),
    .run_i      (run_reg),
    .src_i      (clock_source_select_reg),
    .ext_sync_i (ext_sync),
    .tick_o     (tick)
  );

  // Field decode of the mode register
  assign comparator_enable = module_mode_reg[CACM_MODE_ECOM_BIT];
  assign match_flag_enable = module_mode_reg[CACM_MODE_MAT_BIT];
  assign toggle_enable     = module_mode_reg[CACM_MODE_TOG_BIT];
  assign pwm_enable        = module_mode_reg[CACM_MODE_PWM_BIT];
  assign wide_pwm_select   = module_mode_reg[CACM_MODE_WIDE_BIT];
  assign compare_value     = {compare_high_byte_reg, compare_low_byte_reg};

  // Mode selection from the enable bits
  always_comb begin
    mode = CACM_MODE_IDLE;
    if (pwm_enable && wide_pwm_select) begin
      mode = CACM_MODE_PWM16;
    end else if (pwm_enable && toggle_enable) begin
      mode = CACM_MODE_FREQ;
    end else if (match_flag_enable) begin
      mode = CACM_MODE_TIMER;
    end
  end

  // Comparators look once at each new counter value
  // gated by comparator enable
  assign full_match = fresh_reg && comparator_enable && (count_reg == compare_value);
  assign low_match  = fresh_reg && comparator_enable &&
                      (count_reg[7:0] == compare_low_byte_reg);
  assign overflow   = tick && (count_reg == CACM_CNT_MAX);

  // APB decode; slave answers without wait states
  assign setup    = psel_i && !penable_i;
  assign wr_en    = psel_i && penable_i && pwrite_i && addr_ok;
  assign pready_o = 1'b1;
  assign prdata_o = prdata_reg;

  always_comb begin
    case (paddr_i)
      CACM_ADDR_CTRL, CACM_ADDR_MODE, CACM_ADDR_CMP_LOW, CACM_ADDR_CMP_HIGH,
      CACM_ADDR_COUNTER, CACM_ADDR_STATUS, CACM_ADDR_MASK,
      CACM_ADDR_PIN: addr_ok = 1'b1;
      default:       addr_ok = 1'b0;
    endcase
  end

  assign pslverr_o = psel_i && penable_i && !addr_ok;

  // Read data captured in the setup cycle
  always_comb begin
    prdata_next = prdata_reg;
    if (setup) begin
      case (paddr_i)
        CACM_ADDR_CTRL: prdata_next = 32'({clock_source_select_reg, run_reg});
        CACM_ADDR_MODE:     prdata_next = 32'(module_mode_reg);
        CACM_ADDR_CMP_LOW:  prdata_next = 32'(compare_low_byte_reg);
        CACM_ADDR_CMP_HIGH: prdata_next = 32'(compare_high_byte_reg);
        CACM_ADDR_COUNTER:  prdata_next = 32'(count_reg);
        CACM_ADDR_STATUS:   prdata_next = 32'(status_reg);
        CACM_ADDR_MASK:     prdata_next = 32'(mask_reg);
        CACM_ADDR_PIN:      prdata_next = 32'({pin_sync, pin_reg});
        default:            prdata_next = CACM_DATA_ZERO;
      endcase
    end
  end

  // Control, compare and counter registers
  always_comb begin
    run_next                 = run_reg;
    clock_source_select_next = clock_source_select_reg;
    module_mode_next         = module_mode_reg;
    compare_low_byte_next    = compare_low_byte_reg;
    compare_high_byte_next   = compare_high_byte_reg;
    mask_next                = mask_reg;
    fresh_next               = tick;
    wrap_next                = overflow; // Wrap seen in step with fresh
    count_next               = count_reg;
    if (tick) begin
      count_next = count_reg + 1'b1;
    end
    // low byte advances by high byte
    // high byte zero adds 256, low byte unchanged
    if (mode == CACM_MODE_FREQ && low_match) begin
      compare_low_byte_next = compare_low_byte_reg + compare_high_byte_reg;
    end
    if (wr_en) begin
      case (paddr_i)
        CACM_ADDR_CTRL: begin
          run_next                 = pwdata_i[CACM_CTRL_RUN_BIT];
          clock_source_select_next = pwdata_i[CACM_CTRL_SRC_LSB +: CACM_SRC_W];
        end
        CACM_ADDR_MODE: module_mode_next = pwdata_i[CACM_MODE_W-1:0];
        CACM_ADDR_CMP_LOW: begin
          compare_low_byte_next                = pwdata_i[7:0];
          module_mode_next[CACM_MODE_ECOM_BIT] = 1'b0;
        end
        CACM_ADDR_CMP_HIGH: begin
          compare_high_byte_next               = pwdata_i[7:0];
          module_mode_next[CACM_MODE_ECOM_BIT] = 1'b1;
        end
        CACM_ADDR_COUNTER: count_next = pwdata_i[CACM_CNT_W-1:0];
        CACM_ADDR_MASK:    mask_next  = pwdata_i[CACM_ST_W-1:0];
        default: ;
      endcase
    end
  end

  // Sticky status: events set, write-one clears, set wins
  always_comb begin
    events = '0;
    // full match with flag enable, in any mode but idle
    events[CACM_ST_MATCH_BIT] = full_match && match_flag_enable &&
                                (mode != CACM_MODE_IDLE);
    events[CACM_ST_OVF_BIT]   = overflow;
    status_next = status_reg;
    if (wr_en && paddr_i == CACM_ADDR_STATUS) begin
      status_next = status_reg & ~pwdata_i[CACM_ST_W-1:0];
    end
    status_next = status_next | events;
  end

  assign irq_o = |(status_reg & mask_reg);

  // Module pin behaviour per mode
  always_comb begin
    pin_next = pin_reg;
    case (mode)
      CACM_MODE_FREQ: begin
        if (low_match) begin
          pin_next = ~pin_reg;
        end
      end
      CACM_MODE_PWM16: begin
        if (!comparator_enable) begin
          pin_next = 1'b0;
        end else if (full_match) begin
          pin_next = 1'b1;
        // wrap seen with the match, match wins
        end else if (wrap_reg) begin
          pin_next = 1'b0;
        end
      end
      default: begin
        if (pwm_enable && !comparator_enable) begin
          pin_next = 1'b0;
        end
      end
    endcase
  end

  // Pin is driven only in the output modes
  assign module_io_pin_o    = pin_reg;
  assign module_io_pin_oe_o = (mode == CACM_MODE_FREQ) || (mode == CACM_MODE_PWM16);

  // State registers
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      run_reg                 <= 1'b0;
      clock_source_select_reg <= CACM_SRC_SYS;
      module_mode_reg         <= CACM_MODE_RESET;
      compare_low_byte_reg    <= CACM_BYTE_ZERO;
      compare_high_byte_reg   <= CACM_BYTE_ZERO;
      count_reg               <= CACM_CNT_ZERO;
      fresh_reg               <= 1'b0;
      wrap_reg                <= 1'b0;
      status_reg              <= '0;
      mask_reg                <= '0;
      pin_reg                 <= 1'b0;
      prdata_reg              <= CACM_DATA_ZERO;
    end else begin
      run_reg                 <= run_next;
      clock_source_select_reg <= clock_source_select_next;
      module_mode_reg         <= module_mode_next;
      compare_low_byte_reg    <= compare_low_byte_next;
      compare_high_byte_reg   <= compare_high_byte_next;
      count_reg               <= count_next;
      fresh_reg               <= fresh_next;
      wrap_reg                <= wrap_next;
      status_reg              <= status_next;
      mask_reg                <= mask_next;
      pin_reg                 <= pin_next;
      prdata_reg              <= prdata_next;
    end
  end

endmodule // cacm_top

// ==== shared/cacm_pkg.sv ====
// Constants shared by the counter array compare module and its helpers.
// Assumes a 32-bit APB register bus with byte addresses on word boundaries.
package cacm_pkg;

  // Register byte addresses
  localparam logic [7:0] CACM_ADDR_CTRL     = 8'h00;
  localparam logic [7:0] CACM_ADDR_MODE     = 8'h04;
  localparam logic [7:0] CACM_ADDR_CMP_LOW  = 8'h08;
  localparam logic [7:0] CACM_ADDR_CMP_HIGH = 8'h0C;
  localparam logic [7:0] CACM_ADDR_COUNTER  = 8'h10;
  localparam logic [7:0] CACM_ADDR_STATUS   = 8'h14;
  localparam logic [7:0] CACM_ADDR_MASK     = 8'h18;
  localparam logic [7:0] CACM_ADDR_PIN      = 8'h1C;

  // Control register fields
  localparam int CACM_CTRL_RUN_BIT = 0;
  localparam int CACM_CTRL_SRC_LSB = 1;
  localparam int CACM_SRC_W        = 2;

  // Mode register fields
  localparam int CACM_MODE_PWM_BIT  = 1;
  localparam int CACM_MODE_TOG_BIT  = 2;
  localparam int CACM_MODE_MAT_BIT  = 3;
  localparam int CACM_MODE_ECOM_BIT = 6;
  localparam int CACM_MODE_WIDE_BIT = 7;
  localparam int CACM_MODE_W        = 8;

  // Status and mask fields (same layout)
  localparam int CACM_ST_MATCH_BIT = 0;
  localparam int CACM_ST_OVF_BIT   = 1;
  localparam int CACM_ST_W         = 2;

  // Counter clock sources
  localparam logic [1:0] CACM_SRC_SYS   = 2'h0;
  localparam logic [1:0] CACM_SRC_DIV4  = 2'h1;
  localparam logic [1:0] CACM_SRC_DIV12 = 2'h2;
  localparam logic [1:0] CACM_SRC_EXT   = 2'h3;
  localparam int         CACM_DIV4      = 4;
  localparam int         CACM_DIV12     = 12;
  localparam int         CACM_PRE_W     = 4;

  // Reset values and widths
  localparam int          CACM_CNT_W      = 16;
  localparam logic [15:0] CACM_CNT_MAX    = 16'hFFFF;
  localparam logic [15:0] CACM_CNT_ZERO   = 16'h0000;
  localparam logic [7:0]  CACM_BYTE_ZERO  = 8'h00;
  localparam logic [7:0]  CACM_MODE_RESET = 8'h00;
  localparam logic [31:0] CACM_DATA_ZERO  = 32'h0000_0000;

  // Operating modes decoded from the mode register
  typedef enum logic [1:0] {
    CACM_MODE_TIMER,
    CACM_MODE_FREQ,
    CACM_MODE_PWM16,
    CACM_MODE_IDLE
  } cacm_mode_type;

endpackage

// ==== testbench/cacm_chk.sv ====
// Port-level checker for the counter array compare module.
// Assumes it is bound to cacm_top and sees only its ports.
`timescale 1ns/1ps
module cacm_chk
  import cacm_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        reset_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        ext_count_i,
  input wire logic        module_io_pin_i,
  input wire logic        module_io_pin_o,
  input wire logic        module_io_pin_oe_o,
  input wire logic        irq_o
);
  // Decoded bus phases and address map
  logic acc;
  logic bad;
  logic wr;
  assign acc = psel_i && penable_i;
  assign bad = (paddr_i > CACM_ADDR_PIN) || (paddr_i[1:0] != 2'h0);
  assign wr  = acc && pwrite_i;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  // Bus answers and refusals
  ready_in_access_a:
    assert property (acc |-> pready_o) else $error("pready low in access");
  err_on_map_a:
    assert property (acc |-> pslverr_o == bad) else $error("pslverr wrong for address");
  err_only_access_a:
    assert property (pslverr_o |-> acc) else $error("pslverr outside access");
  bad_read_zero_a:
    assert property (acc && !pwrite_i && bad |-> prdata_o == CACM_DATA_ZERO)
      else $error("unmapped read not zero");
  rdata_hold_a:
    assert property (acc |=> $stable(prdata_o)) else $error("read data moved");
  pin_readback_a:
    assert property (acc && !pwrite_i && paddr_i == CACM_ADDR_PIN
                     |-> prdata_o[0] == $past(module_io_pin_o))
      else $error("pin readback wrong");
  // Interrupt only drops on software writes
  irq_fall_a:
    assert property ($fell(irq_o) |->
                     $past(wr && (paddr_i == CACM_ADDR_STATUS || paddr_i == CACM_ADDR_MASK)))
      else $error("irq dropped without write");
  mask_off_a:
    assert property (wr && paddr_i == CACM_ADDR_MASK && pwdata_i[1:0] == 2'h0 |=> !irq_o)
      else $error("irq high while masked");
  // Pin drive follows mode register only
  oe_by_mode_a:
    assert property ($changed(module_io_pin_oe_o) |-> $past(wr && paddr_i == CACM_ADDR_MODE))
      else $error("pin enable moved without mode write");
endmodule // cacm_chk

bind cacm_top cacm_chk u_cacm_chk (
  .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .ext_count_i(ext_count_i),
  .module_io_pin_i(module_io_pin_i), .module_io_pin_o(module_io_pin_o),
  .module_io_pin_oe_o(module_io_pin_oe_o), .irq_o(irq_o)
);

// ==== testbench/cacm_pin_model.sv ====
// External logic on the module pin: a slow level source.
// Assumes the module drive wins whenever its enable is high.
`timescale 1ns/1ps
module cacm_pin_model (
  input  wire logic sys_clk_i,
  input  wire logic mod_pin_i,
  input  wire logic mod_oe_i,
  output logic      pin_level_o
);
  logic [2:0] div_reg;
  logic       lvl_reg;
  initial begin
    div_reg = 3'h0;
    lvl_reg = 1'b0;
  end
  // hold eight clocks
  // Own level changes only every eight clocks
  always @(posedge sys_clk_i) begin
    div_reg <= div_reg + 3'h1;
    if (div_reg == 3'h7) lvl_reg <= !lvl_reg;
  end
  // Wire level from both drivers
  assign pin_level_o = mod_oe_i ? mod_pin_i : lvl_reg;
endmodule // cacm_pin_model

// ==== testbench/cacm_top_tb_top.sv ====
// Self-checking bench for the compare module over APB.
// Assumes the pin model on the far side and a bound checker.
`timescale 1ns/1ps
module cacm_top_tb_top;
  import cacm_pkg::*;
  logic        sys_clk_i, reset_n_i, psel_i, penable_i, pwrite_i, ext_count_i;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, r;
  logic        pready_o, pslverr_o, pin_in, pin_o, pin_oe, irq_o;
  int          fail_count, compares, n, h1, h2;

  cacm_top u_cacm_top (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .ext_count_i(ext_count_i), .module_io_pin_i(pin_in), .module_io_pin_o(pin_o),
    .module_io_pin_oe_o(pin_oe), .irq_o(irq_o));
  cacm_pin_model u_cacm_pin_model (.sys_clk_i(sys_clk_i), .mod_pin_i(pin_o),
    .mod_oe_i(pin_oe), .pin_level_o(pin_in));

  // 250 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = !sys_clk_i;
  end

  task automatic close_out();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
    int k;
    @(posedge sys_clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 50);
    if (k >= 50) begin
      fail_count++;
      close_out();
    end
    q = prdata_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(a, 1'b1, d, x);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(a, 1'b0, 32'h0, q);
  endtask

  // Wait at falling edges until irq (sel) or pin reaches a level
  task automatic wait_for(input bit sel, input logic lvl, output int k);
    k = 0;
    do begin
      @(negedge sys_clk_i);
      k++;
    end while ((sel ? irq_o : pin_o) !== lvl && k < 1000);
    if (k >= 1000) begin
      fail_count++;
      close_out();
    end
  endtask

  // Length of one whole phase of the pin at a level
  task automatic phase(input logic lvl, output int k);
    wait_for(1'b0, !lvl, k);
    wait_for(1'b0, lvl, k);
    wait_for(1'b0, !lvl, k);
  endtask

  // Counter advance over twelve clocks for a source
  task automatic rate(input logic [1:0] s, input logic [31:0] e);
    logic [31:0] a;
    logic [31:0] b;
    wr(CACM_ADDR_COUNTER, 32'h0);
    wr(CACM_ADDR_CTRL, {29'h0, s, 1'b1});
    rd(CACM_ADDR_COUNTER, a);
    repeat (4) rd(CACM_ADDR_COUNTER, b);
    chk("count step", e, {16'h0, b[15:0] - a[15:0]});
  endtask

  // Main sequence
  initial begin
    {reset_n_i, psel_i, penable_i, pwrite_i, ext_count_i} = 5'h00;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    fail_count = 0;
    compares = 0;
    repeat (20) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    // Reset values, read-only pin register, unmapped place
    for (int i = 0; i < 8; i++) begin
      rd(8'(i * 4), r);
      chk("reset value", 32'h0, (i == 7) ? (r & 32'h1) : r);
    end
    wr(CACM_ADDR_PIN, 32'h1);
    rd(CACM_ADDR_PIN, r);
    chk("pin reg ro", 32'h0, r & 32'h1);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, r);
    chk("unmapped", 32'h0, r);
    // Counter sources
    rate(CACM_SRC_SYS, 32'd12);
    rate(CACM_SRC_DIV4, 32'd3);
    rate(CACM_SRC_DIV12, 32'd1);
    wr(CACM_ADDR_CTRL, 32'h7);
    rd(CACM_ADDR_COUNTER, h1);
    repeat (5) begin
      @(posedge sys_clk_i) ext_count_i <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      ext_count_i <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
    end
    repeat (8) @(posedge sys_clk_i);
    rd(CACM_ADDR_COUNTER, r);
    chk("ext count", 32'd5, r - h1);
    // Software timer: disabled comparator first
    wr(CACM_ADDR_CTRL, 32'h0);
    wr(CACM_ADDR_COUNTER, 32'h0);
    wr(CACM_ADDR_STATUS, 32'h3);
    wr(CACM_ADDR_MODE, 32'h48);
    wr(CACM_ADDR_CMP_LOW, 32'h10);
    rd(CACM_ADDR_MODE, r);
    chk("mode after low", 32'h08, r);
    wr(CACM_ADDR_CTRL, 32'h1);
    repeat (40) @(posedge sys_clk_i);
    wr(CACM_ADDR_CTRL, 32'h0);
    rd(CACM_ADDR_STATUS, r);
    chk("flag while off", 32'h0, r);
    wr(CACM_ADDR_CMP_HIGH, 32'h0);
    rd(CACM_ADDR_MODE, r);
    chk("mode after high", 32'h48, r);
    wr(CACM_ADDR_COUNTER, 32'h0);
    wr(CACM_ADDR_MASK, 32'h1);
    wr(CACM_ADDR_CTRL, 32'h1);
    wait_for(1'b1, 1'b1, n);
    wr(CACM_ADDR_CTRL, 32'h0);
    rd(CACM_ADDR_STATUS, r);
    chk("timer flag", 32'h1, r);
    wr(CACM_ADDR_MASK, 32'h0);
    @(negedge sys_clk_i);
    chk("irq masked", 32'h0, irq_o);
    wr(CACM_ADDR_MASK, 32'h1);
    @(negedge sys_clk_i);
    chk("flag sticky", 32'h1, irq_o);
    wr(CACM_ADDR_STATUS, 32'h1);
    @(negedge sys_clk_i);
    chk("irq cleared", 32'h0, irq_o);
    // Frequency output
    wr(CACM_ADDR_MODE, 32'h06);
    wr(CACM_ADDR_CMP_LOW, 32'h0);
    wr(CACM_ADDR_CMP_HIGH, 32'h4);
    wr(CACM_ADDR_CTRL, 32'h1);
    rd(CACM_ADDR_MODE, r);
    chk("freq mode", 32'h46, r);
    chk("freq drive", 32'h1, pin_oe);
    phase(1'b0, n);
    chk("half period", 32'd4, n);
    wr(CACM_ADDR_CMP_HIGH, 32'h0);
    phase(1'b0, n);
    phase(1'b0, n);
    chk("half period 256", 32'd256, n);
    // Driven level comes back through the pin sampler
    repeat (3) @(posedge sys_clk_i);
    rd(CACM_ADDR_PIN, r);
    chk("pin sampled", 32'h3, r & 32'h3);
    // Wide PWM
    wr(CACM_ADDR_MODE, 32'h8A);
    wr(CACM_ADDR_CMP_LOW, 32'h0);
    wr(CACM_ADDR_CMP_HIGH, 32'hFF);
    wr(CACM_ADDR_COUNTER, 32'hFEF0);
    wr(CACM_ADDR_STATUS, 32'h3);
    phase(1'b1, h1);
    rd(CACM_ADDR_STATUS, r);
    chk("pwm flags", 32'h3, r);
    wr(CACM_ADDR_COUNTER, 32'hFEFC);
    wait_for(1'b0, 1'b1, n);
    wr(CACM_ADDR_CMP_LOW, 32'h80);
    repeat (4) @(negedge sys_clk_i);
    chk("pwm off pin", 32'h0, pin_o);
    wr(CACM_ADDR_COUNTER, 32'hFF40);
    wr(CACM_ADDR_CMP_HIGH, 32'hFF);
    phase(1'b1, h2);
    chk("duty step", 32'd128, h1 - h2);
    chk("pwm high", 32'd256, h1);
    // Smallest duty: one counter clock high
    wr(CACM_ADDR_CMP_LOW, 32'hFF);
    wr(CACM_ADDR_COUNTER, 32'hFFF0);
    wr(CACM_ADDR_CMP_HIGH, 32'hFF);
    phase(1'b1, n);
    chk("min duty", 32'd1, n);
    close_out();
  end
endmodule // cacm_top_tb_top
